// ### include/fsr_pkg.sv
package fsr_pkg;
   // Clock and flash bus timing
   localparam int CLK_MHZ        = 25;
   localparam int ADDR_W         = 21;
   localparam int WE_PULSE_NS    = 60;
   localparam int RD_ACC_NS      = 100;
   localparam int WE_PULSE_CYC   = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_ACC_CYC     = (RD_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_CYC       = 2;
   localparam int RECOV_CYC      = 1;
   localparam int RESUME_GAP_US  = 500;
   localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;

   // Flash opcodes
   localparam logic [7:0] OPC_SUSPEND    = 8'hB0;
   localparam logic [7:0] OPC_RESUME     = 8'hD0;
   localparam logic [7:0] OPC_RD_STATUS  = 8'h70;
   localparam logic [7:0] OPC_CLR_STATUS = 8'h50;
   localparam logic [7:0] OPC_RD_ARRAY   = 8'hFF;

   // Status bit positions and error group
   localparam int         SB_WSM_READY  = 7;
   localparam int         SB_ERASE_SUSP = 6;
   localparam int         SB_PROG_SUSP  = 2;
   localparam logic [7:0] ERR_MASK      = 8'h3A;

   // Wishbone register byte offsets
   localparam logic [4:0] REG_CMD    = 5'h00;
   localparam logic [4:0] REG_ADDR   = 5'h04;
   localparam logic [4:0] REG_WDATA  = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0C;
   localparam logic [4:0] REG_PINS   = 5'h10;

   typedef enum logic [2:0] {
      OP_SUSPEND, OP_RESUME, OP_RD_STATUS, OP_CLR_STATUS,
      OP_RD_ARRAY, OP_WRITE, OP_READ
   } fsr_op_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0]       dq_o;
      logic              dq_oe;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
   } fsr_bus_t;

   typedef struct packed {
      logic rst_n;
      logic wp;
      logic vpp_en;
   } fsr_ctl_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [4:0]  adr;
      logic [31:0] dat;
   } fsr_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } fsr_wb_rsp_t;

   localparam fsr_bus_t BUS_IDLE = '{addr: '0, dq_o: '0, dq_oe: 1'b0,
                                     ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage : fsr_pkg

// ### hdl/fsr_cycle.sv
`timescale 1ns/10ps
module fsr_cycle (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  req,
   input  wire logic                  we,
   input  wire logic [fsr_pkg::ADDR_W-1:0] addr,
   input  wire logic [15:0]           wdata,
   input  wire logic [15:0]           dq_i,
   output logic                       done,
   output logic [15:0]                rdata,
   output fsr_pkg::fsr_bus_t          bus
);
   import fsr_pkg::*;

   localparam logic [3:0] WR_LEN  = 4'(WE_PULSE_CYC);
   localparam logic [3:0] RD_LEN  = 4'(RD_ACC_CYC + SYNC_CYC);
   localparam logic [3:0] REC_LEN = 4'(RECOV_CYC);

   typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} fsr_cst_t;
   typedef struct packed {
      fsr_cst_t    st;
      logic [3:0]  cnt;
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] rdata;
      logic        done;
      fsr_bus_t    bus;
   } fsr_cyc_st_t;

   localparam fsr_cyc_st_t CYC_RST = '{st: CY_IDLE, cnt: '0, s1: '0,
      s2: '0, rdata: '0, done: 1'b0, bus: BUS_IDLE};

   fsr_cyc_st_t cs_r;
   fsr_cyc_st_t cs_nxt;

   always_comb begin
      cs_nxt      = cs_r;
      cs_nxt.done = 1'b0;
      // Data pins are asynchronous to clk
      cs_nxt.s1   = dq_i;
      cs_nxt.s2   = cs_r.s1;
      unique case (cs_r.st)
         CY_IDLE: begin
            if (req) begin
               cs_nxt.bus.addr  = addr;
               cs_nxt.bus.dq_o  = wdata;
               cs_nxt.bus.dq_oe = we;
               cs_nxt.bus.ce_n  = 1'b0;
               cs_nxt.bus.we_n  = !we;
               cs_nxt.bus.oe_n  = we;
               cs_nxt.cnt       = we ? WR_LEN : RD_LEN;
               cs_nxt.st        = CY_ACT;
            end
         end
         CY_ACT: begin
            if (cs_r.cnt == 4'h1) begin
               // Access time plus synchroniser delay has elapsed
               if (!cs_r.bus.oe_n) begin
                  cs_nxt.rdata = cs_r.s2;
               end
               cs_nxt.bus.ce_n = 1'b1;
               cs_nxt.bus.we_n = 1'b1;
               cs_nxt.bus.oe_n = 1'b1;
               cs_nxt.done     = 1'b1;
               cs_nxt.cnt      = REC_LEN;
               cs_nxt.st       = CY_REC;
            end else begin
               cs_nxt.cnt = cs_r.cnt - 4'h1;
            end
         end
         CY_REC: begin
            // Write data is held one cycle past the strobe for hold time
            if (cs_r.cnt == 4'h1) begin
               cs_nxt.bus.dq_oe = 1'b0;
               cs_nxt.st        = CY_IDLE;
            end else begin
               cs_nxt.cnt = cs_r.cnt - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cs_r <= CYC_RST;
      end else begin
         cs_r <= cs_nxt;
      end
   end

   assign done  = cs_r.done;
   assign rdata = cs_r.rdata;
   assign bus   = cs_r.bus;
endmodule : fsr_cycle

// ### hdl/fsr_host.sv
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - Host clears status before any retry or recovery.
// - Host follows suspend with read-status to check.
// - Host holds reset released and keeps protect, voltage pins steady while suspended.
// - Host spaces erase suspend after resume.
// - Host reads status after program suspend.
// - Host resumes program before erase, else ignored.
// - Host spaces program suspend after resume.
module fsr_host #(
   parameter int GAP_CYC = fsr_pkg::RESUME_GAP_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire fsr_pkg::fsr_wb_req_t  wb_i,
   output fsr_pkg::fsr_wb_rsp_t       wb_o,
   output fsr_pkg::fsr_bus_t          bus,
   input  wire logic [15:0]           dq_i,
   output fsr_pkg::fsr_ctl_t          ctl
);
   import fsr_pkg::*;

   localparam int GAP_W = $clog2(GAP_CYC + 1);

   typedef enum logic [1:0] {M_IDLE, M_CMD, M_STAT, M_READ} fsr_mst_t;
   typedef struct packed {
      fsr_mst_t          st;
      fsr_op_t           op;
      logic              tgt_prog;
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
      logic [15:0]       rdata;
      logic [7:0]        status;
      logic              err;
      logic              esusp;
      logic              psusp;
      logic              refused;
      logic              pin_rst;
      logic              pin_wp;
      logic              pin_vpp;
      logic [GAP_W-1:0]  gap;
      logic              ack;
      logic [31:0]       dat;
   } fsr_host_st_t;

   fsr_host_st_t st_r;
   fsr_host_st_t st_nxt;
   logic         acc;
   logic         start;
   fsr_op_t      new_op;
   logic         cy_req;
   logic         cy_we;
   logic [15:0]  cy_data;
   logic         cy_done;
   logic [15:0]  cy_rdata;
   logic         susp;

   function automatic logic cmd_ok(input fsr_op_t op, input logic tgt_prog,
                                   input fsr_host_st_t s);
      logic ok;
      ok = 1'b1;
      if (s.err && op != OP_RD_STATUS && op != OP_CLR_STATUS) begin
         ok = 1'b0;
      end
      if (op == OP_SUSPEND && s.gap != '0) begin
         ok = 1'b0;
      end
      if (op == OP_RESUME && !tgt_prog && s.psusp) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : cmd_ok

   function automatic logic [15:0] cmd_word(input fsr_op_t op,
                                            input logic [15:0] wd);
      logic [15:0] w;
      w = wd;
      unique case (op)
         OP_SUSPEND:    w = {8'h00, OPC_SUSPEND};
         OP_RESUME:     w = {8'h00, OPC_RESUME};
         OP_RD_STATUS:  w = {8'h00, OPC_RD_STATUS};
         OP_CLR_STATUS: w = {8'h00, OPC_CLR_STATUS};
         OP_RD_ARRAY:   w = {8'h00, OPC_RD_ARRAY};
         default:       w = wd;
      endcase
      return w;
   endfunction : cmd_word

   assign susp   = st_r.esusp || st_r.psusp;
   assign new_op = fsr_op_t'(wb_i.dat[2:0]);

   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = 1'b0;
      start      = 1'b0;
      acc        = wb_i.cyc && wb_i.stb && !st_r.ack;
      if (st_r.gap != '0) begin
         st_nxt.gap = st_r.gap - 1'b1;
      end
      if (acc) begin
         st_nxt.ack = 1'b1;
         case (wb_i.adr)
            REG_CMD:    st_nxt.dat = {28'h0, st_r.tgt_prog, st_r.op};
            REG_ADDR:   st_nxt.dat = 32'(st_r.addr);
            REG_WDATA:  st_nxt.dat = {16'h0000, st_r.wdata};
            REG_STATUS: st_nxt.dat = {st_r.rdata, 3'h0, st_r.refused,
                                      st_r.psusp, st_r.esusp, st_r.err,
                                      st_r.st != M_IDLE, st_r.status};
            REG_PINS:   st_nxt.dat = {29'h0, st_r.pin_vpp, st_r.pin_wp,
                                      st_r.pin_rst};
            default:    st_nxt.dat = 32'h0000_0000;
         endcase
         if (wb_i.we) begin
            case (wb_i.adr)
               REG_CMD: begin
                  if (st_r.st == M_IDLE && wb_i.dat[2:0] <= 3'(OP_READ)
                      && cmd_ok(new_op, wb_i.dat[3], st_r)) begin
                     start           = 1'b1;
                     st_nxt.op       = new_op;
                     st_nxt.tgt_prog = wb_i.dat[3];
                     st_nxt.refused  = 1'b0;
                     st_nxt.st = (new_op == OP_READ) ? M_READ : M_CMD;
                  end else begin
                     st_nxt.refused = 1'b1;
                  end
               end
               REG_ADDR:  st_nxt.addr  = wb_i.dat[ADDR_W-1:0];
               REG_WDATA: st_nxt.wdata = wb_i.dat[15:0];
               REG_PINS: begin
                  // Pin levels are frozen while anything is suspended
                  if (!susp) begin
                     st_nxt.pin_rst = wb_i.dat[0];
                     st_nxt.pin_wp  = wb_i.dat[1];
                     st_nxt.pin_vpp = wb_i.dat[2];
                  end
               end
               default: ;
            endcase
         end
      end
      unique case (st_r.st)
         M_IDLE: ;
         M_CMD: begin
            if (cy_done) begin
               if (st_r.op == OP_SUSPEND) begin
                  st_nxt.st = M_STAT;
               end else if (st_r.op == OP_RESUME) begin
                  st_nxt.gap = GAP_W'(GAP_CYC);
                  if (st_r.tgt_prog) begin
                     st_nxt.psusp = 1'b0;
                  end else begin
                     st_nxt.esusp = 1'b0;
                  end
                  st_nxt.st = M_READ;
               end else if (st_r.op == OP_CLR_STATUS) begin
                  st_nxt.err = 1'b0;
                  st_nxt.st  = M_IDLE;
               end else if (st_r.op == OP_WRITE) begin
                  st_nxt.st = M_IDLE;
               end else begin
                  st_nxt.st = M_READ;
               end
            end
         end
         M_STAT: begin
            if (cy_done) begin
               st_nxt.st = M_READ;
            end
         end
         M_READ: begin
            if (cy_done) begin
               st_nxt.st = M_IDLE;
               if (st_r.op == OP_RD_ARRAY || st_r.op == OP_READ) begin
                  st_nxt.rdata = cy_rdata;
               end else begin
                  st_nxt.status = cy_rdata[7:0];
                  // Errors accumulate until software clears them
                  if ((cy_rdata[7:0] & ERR_MASK) != 8'h00) begin
                     st_nxt.err = 1'b1;
                  end
                  if (st_r.op != OP_RESUME) begin
                     st_nxt.esusp = cy_rdata[SB_WSM_READY]
                                    && cy_rdata[SB_ERASE_SUSP]
                                    || cy_rdata[SB_ERASE_SUSP]
                                    && st_r.esusp;
                     st_nxt.psusp = cy_rdata[SB_WSM_READY]
                                    && cy_rdata[SB_PROG_SUSP];
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cy_req  = st_r.st != M_IDLE;
   assign cy_we   = st_r.st != M_READ;
   assign cy_data = (st_r.st == M_STAT) ? {8'h00, OPC_RD_STATUS}
                                        : cmd_word(st_r.op, st_r.wdata);

   fsr_cycle u_cycle (
      .clk   (clk),
      .nrst  (nrst),
      .req   (cy_req),
      .we    (cy_we),
      .addr  (st_r.addr),
      .wdata (cy_data),
      .dq_i  (dq_i),
      .done  (cy_done),
      .rdata (cy_rdata),
      .bus   (bus)
   );

   assign wb_o.ack   = st_r.ack;
   assign wb_o.dat   = st_r.dat;
   assign ctl.rst_n  = !st_r.pin_rst || susp;
   assign ctl.wp     = st_r.pin_wp;
   assign ctl.vpp_en = st_r.pin_vpp;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_susp_written;
      st_r.st == M_CMD && st_r.op == OP_SUSPEND && cy_done;
   endsequence
   sequence s_status_asked;
      st_r.st == M_STAT && cy_we && cy_data == {8'h00, OPC_RD_STATUS};
   endsequence

   a_err_cmd_gate: assert property (start && st_r.err |->
      st_nxt.op == OP_RD_STATUS || st_nxt.op == OP_CLR_STATUS)
      else $error("command started while error pending");
   a_err_sticky_hold: assert property (st_r.err && !(st_r.st == M_CMD
      && st_r.op == OP_CLR_STATUS && cy_done) |=> st_r.err)
      else $error("error flag lost without clear status");
   a_susp_then_stat: assert property (s_susp_written |=>
      s_status_asked)
      else $error("suspend not followed by read status");
   a_stat_then_read: assert property (s_status_asked ##0 cy_done
      |=> st_r.st == M_READ && !cy_we)
      else $error("status write not followed by a read");
   a_susp_rst_held: assert property (susp |-> ctl.rst_n)
      else $error("reset pin asserted during suspend");
   a_susp_pins_frozen: assert property (susp && $past(susp) |->
      $stable(ctl.wp) && $stable(ctl.vpp_en))
      else $error("protect or voltage pin moved during suspend");
   a_gap_susp_block: assert property (start && st_nxt.op == OP_SUSPEND
      |-> st_r.gap == '0)
      else $error("suspend issued too soon after resume");
   a_gap_resume_load: assert property (st_r.st == M_CMD
      && st_r.op == OP_RESUME && cy_done |=> st_r.gap == GAP_W'(GAP_CYC)
      ##1 st_r.gap == GAP_W'(GAP_CYC - 1))
      else $error("resume gap timer not loaded");
   a_erase_res_order: assert property (start
      && st_nxt.op == OP_RESUME && !st_nxt.tgt_prog |-> !st_r.psusp)
      else $error("erase resumed before suspended program");
endmodule : fsr_host

// ### bench/fsr_flash_model.sv
`timescale 1ns/10ps
module fsr_flash_model #(
   parameter logic [15:0] ARRAY_WORD = 16'h5A3C
) (
   input  wire fsr_pkg::fsr_bus_t bus,
   input  wire logic [1:0]        run,
   input  wire logic [7:0]        err_set,
   output logic [15:0]            dq_i
);
   import fsr_pkg::*;
   logic        er_act, pg_act, esusp, psusp, st_mode, xs_mode, wsel;
   logic [7:0]  err_r;
   logic [15:0] drv;
   logic        ready;
   logic [7:0]  sr;
   // Running and not suspended means busy
   assign ready = !(er_act && !esusp) && !(pg_act && !psusp);
   assign sr    = {ready, esusp, err_r[5:3], psusp, err_r[1], 1'b0};
   initial begin
      {er_act, pg_act, esusp, psusp, st_mode, xs_mode, wsel} = '0;
      err_r = 8'h00;
      drv   = 16'h0000;
   end
   always @(posedge run[0]) er_act = 1'b1;
   always @(negedge run[0]) er_act = 1'b0;
   always @(posedge run[1]) pg_act = 1'b1;
   always @(negedge run[1]) pg_act = 1'b0;
   // Errors pile up until the clear opcode
   always @(err_set) err_r = err_r | (err_set & ERR_MASK);
   always @(negedge bus.we_n) wsel = !bus.ce_n;
   always @(posedge bus.we_n) begin
      if (wsel) begin
         xs_mode = 1'b0;
         case (bus.dq_o[7:0])
            OPC_SUSPEND: begin
               if (pg_act && !psusp) psusp = 1'b1;
               else if (er_act && !esusp) esusp = 1'b1;
               st_mode = !ready;
               if (esusp || psusp) st_mode = 1'b1;
            end
            OPC_RD_STATUS: st_mode = 1'b1;
            OPC_CLR_STATUS: err_r = 8'h00;
            OPC_RD_ARRAY: st_mode = 1'b0;
            8'hE8: xs_mode = 1'b1;
            OPC_RESUME: begin
               // Program first; erase waits for it
               if (psusp) begin
                  psusp   = 1'b0;
                  st_mode = 1'b1;
               end else if (esusp && !pg_act) begin
                  esusp   = 1'b0;
                  st_mode = 1'b1;
               end else st_mode = 1'b0;
            end
            default: ;
         endcase
      end
   end
   always @(negedge bus.oe_n)
      drv = xs_mode ? 16'h0080 : st_mode ? {8'h00, sr} : ARRAY_WORD;
   // Released bus shows the inverse so stale data cannot pass
   assign dq_i = (!bus.ce_n && !bus.oe_n) ? drv : ~drv;
endmodule : fsr_flash_model

// ### bench/fsr_host_bench.sv
`timescale 1ns/10ps
module fsr_host_bench;
   import fsr_pkg::*;
   localparam int GAP = 40;
   logic        clk, nrst;
   fsr_wb_req_t wb_i;
   fsr_wb_rsp_t wb_o;
   fsr_bus_t    bus;
   fsr_ctl_t    ctl;
   logic [15:0] dq_i;
   logic [1:0]  run;
   logic [7:0]  err_set;
   logic [31:0] st;
   int          error_cnt, n_tests;

   fsr_host #(.GAP_CYC(GAP)) dut_u (.clk(clk), .nrst(nrst), .wb_i(wb_i),
      .wb_o(wb_o), .bus(bus), .dq_i(dq_i), .ctl(ctl));
   fsr_flash_model flash_u (.bus(bus), .run(run), .err_set(err_set),
      .dq_i(dq_i));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wb_cyc(input logic we, input logic [4:0] adr,
                         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_o.ack !== 1'b1 && n < 50);
      q = wb_o.dat;
      wb_i <= '0;
      // A slave that never answers ends the run here
      if (n >= 50) begin
         chk(32'h0, 32'h1);
         final_report();
      end
   endtask : wb_cyc

   // Issue an order, then poll until the sequencer is idle
   task automatic cmd(input logic [3:0] c);
      logic [31:0] q;
      int n;
      wb_cyc(1'b1, REG_CMD, {28'h0, c}, q);
      n = 0;
      do begin
         wb_cyc(1'b0, REG_STATUS, 32'h0, q);
         n++;
      end while (q[8] !== 1'b0 && n < 100);
      if (n >= 100) begin
         chk(32'h0, 32'h1);
         final_report();
      end
      st = q;
   endtask : cmd

   task automatic t_reset;
      logic [31:0] q;
      wb_cyc(1'b0, REG_STATUS, 32'h0, q);
      chk(q, 32'h0);
      wb_cyc(1'b0, 5'h14, 32'h0, q);
      chk(q, 32'h0);
      chk({29'h0, ctl}, 32'h4);
      wb_cyc(1'b1, REG_PINS, 32'h6, q);
      @(posedge clk);
      chk({29'h0, ctl}, 32'h7);
      wb_cyc(1'b1, REG_PINS, 32'h0, q);
      $display("test reset done");
   endtask : t_reset

   task automatic t_suspend;
      logic [31:0] q;
      run[0] <= 1'b1;
      cmd(4'h0);
      chk({st[10], st[7:0]}, 9'h1C0);
      // All three pin bits requested; none may move while suspended
      wb_cyc(1'b1, REG_PINS, 32'h7, q);
      @(posedge clk);
      chk({31'h0, ctl.rst_n}, 32'h1);
      chk({29'h0, ctl}, 32'h4);
      wb_cyc(1'b0, REG_PINS, 32'h0, q);
      chk(q, 32'h0);
      run[1] <= 1'b1;
      cmd(4'h2);
      chk(st[7:0], 8'h40);
      cmd(4'h0);
      chk({st[11], st[7:0]}, 9'h1C4);
      cmd(4'h1);
      chk(st[12:10], 3'h7);
      cmd(4'h9);
      chk({st[12:11], st[7:0]}, 10'h040);
      cmd(4'h0);
      chk(st[12], 1'b1);
      run[1] <= 1'b0;
      repeat (GAP + 10) @(posedge clk);
      cmd(4'h1);
      chk({st[10], st[7:0]}, 9'h000);
      cmd(4'h0);
      chk(st[12], 1'b1);
      run[0] <= 1'b0;
      repeat (GAP + 10) @(posedge clk);
      cmd(4'h0);
      chk({st[12:10], st[7:0]}, 11'h080);
      $display("test suspend and resume done");
   endtask : t_suspend

   task automatic t_errors;
      logic [7:0] codes [4] = '{8'h08, 8'h02, 8'h10, 8'h30};
      foreach (codes[i]) begin
         err_set <= codes[i];
         cmd(4'h2);
         chk({st[9], st[7:0]}, {1'b1, 8'h80 | codes[i]});
         err_set <= 8'h00;
         cmd(4'h2);
         chk(st[7:0], 8'h80 | codes[i]);
         cmd(4'h4);
         chk(st[12], 1'b1);
         cmd(4'h3);
         chk(st[9], 1'b0);
         cmd(4'h2);
         chk(st[7:0], 8'h80);
      end
      cmd(4'h4);
      chk(st[31:16], 16'h5A3C);
      $display("test errors done");
   endtask : t_errors

   // Raw write of the buffer setup opcode, then a raw read of its answer
   task automatic t_raw;
      logic [31:0] q;
      wb_cyc(1'b1, REG_ADDR, 32'h0001_2345, q);
      wb_cyc(1'b1, REG_WDATA, 32'h0000_00E8, q);
      cmd(4'h5);
      chk({11'h0, bus.addr}, 32'h0001_2345);
      chk({28'h0, bus.ce_n, bus.oe_n, bus.we_n, bus.dq_oe}, 32'hE);
      wb_cyc(1'b0, REG_WDATA, 32'h0, q);
      chk(q, 32'h0000_00E8);
      cmd(4'h6);
      chk(st[31:16], 16'h0080);
      cmd(4'h4);
      chk(st[31:16], 16'h5A3C);
      wb_cyc(1'b0, REG_CMD, 32'h0, q);
      chk(q, 32'h4);
      $display("test raw access done");
   endtask : t_raw

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   initial begin
      error_cnt = 0;
      n_tests   = 0;
      nrst      = 1'b0;
      wb_i      = '0;
      run       = 2'b00;
      err_set   = 8'h00;
      st        = 32'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_suspend();
      t_errors();
      t_raw();
      final_report();
   end
endmodule : fsr_host_bench
